// ### smsel_pkg.sv
// smsel_pkg: types and constants for the stop mode selector
// assumes a single 50 MHz core clock domain
package smsel_pkg;
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned WAKE_SEL_W = 3;
	localparam logic [WAKE_SEL_W-1:0] WAKE_SEL_OFF = 3'h0;
	localparam int unsigned SYNC_STAGES = 3;
	localparam logic [3:0] DBG_ST_OK = 4'h0;
	localparam logic [3:0] DBG_ST_STOPPED = 4'h1;
	localparam logic [3:0] DBG_ST_REJECT = 4'h2;

	typedef enum logic [1:0] {
		SM_CMD_MEM_STATUS,
		SM_CMD_ENTER_DEBUG,
		SM_CMD_NONINTRUSIVE,
		SM_CMD_ACTIVE_ONLY
	} smsel_cmd_t;

	typedef struct packed {
		logic bdm_enable;
		logic lowv_detect_enable;
		logic lowv_stop_enable;
		logic stop_instr_enable;
		logic partial_powerdown_select;
		logic osc_run_in_stop;
		logic adc_async_clk_enable;
		logic [WAKE_SEL_W-1:0] periodic_wake_select;
	} smsel_cfg_t;

	typedef struct packed {
		logic cpu_standby;
		logic cpu_off;
		logic ram_standby;
		logic periph_clk_en;
		logic debug_clk_en;
		logic regulator_active;
		logic icg_active;
		logic adc_active;
		logic wake_timer_run;
		logic pins_held;
	} smsel_pwr_t;

	typedef struct packed {
		logic valid;
		smsel_cmd_t cmd;
	} smsel_dbg_req_t;

	typedef struct packed {
		logic valid;
		logic accepted;
		logic do_access;
		logic [3:0] status;
	} smsel_dbg_rsp_t;
endpackage

// ### smsel_sync.sv
// smsel_sync: three-stage synchroniser with agree-filter for pin inputs
// assumes input is asynchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
module smsel_sync (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic pin_in,
	output logic level_out
);
	import smsel_pkg::*;
	typedef struct packed {
		logic [SYNC_STAGES-1:0] sr;
		logic lvl;
	} smsel_sync_st_t;
	smsel_sync_st_t st_q, st_d;
	always_comb begin
		st_d = st_q;
		st_d.sr = {st_q.sr[SYNC_STAGES-2:0], pin_in};
		// only second and third stage are compared, first stays private
		if (st_q.sr[1] == st_q.sr[2]) begin
			st_d.lvl = st_q.sr[2];
		end
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			// pins idle high, so no false wake right after reset
			st_q <= '1;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end
	assign level_out = st_q.lvl;
endmodule // smsel_sync
`default_nettype wire

// ### smsel_dbg_filter.sv
// smsel_dbg_filter: decides which serial debug commands are serviced
// assumes requests are single-cycle pulses in the core clock domain
`timescale 1ns/10ps
`default_nettype none
module smsel_dbg_filter (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic stopped,
	input wire logic active_bg,
	input wire smsel_pkg::smsel_dbg_req_t req,
	output smsel_pkg::smsel_dbg_rsp_t rsp
);
	import smsel_pkg::*;
	smsel_dbg_rsp_t st_q, st_d;
	always_comb begin
		st_d = '0;
		if (req.valid) begin
			st_d.valid = 1'b1;
			st_d.status = DBG_ST_OK;
			if (stopped && !active_bg) begin
				case (req.cmd)
					SM_CMD_MEM_STATUS: begin
						st_d.accepted = 1'b1;
						st_d.status = DBG_ST_STOPPED;
					end
					SM_CMD_ENTER_DEBUG: begin
						st_d.accepted = 1'b1;
					end
					default: begin
						st_d.status = DBG_ST_REJECT;
					end
				endcase
			end else if (req.cmd == SM_CMD_ACTIVE_ONLY && !active_bg) begin
				st_d.status = DBG_ST_REJECT;
			end else begin
				st_d.accepted = 1'b1;
				st_d.do_access = (req.cmd != SM_CMD_ENTER_DEBUG);
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end
	assign rsp = st_q;
endmodule // smsel_dbg_filter
`default_nettype wire

// ### smsel_top.sv
// smsel_top: stop mode selection and power/clock gating control
// assumes cpu pulses stop_instr once; wake pins are asynchronous
//
// Notes on behaviour
// - background debug entry from run only when bdm_enable is set
// - bdm_enable at stop entry keeps debug clocks running
// - bdm_enable at stop entry keeps regulator in full regulation
// - deep stop request with bdm_enable enters retained stop instead
// - while stopped only enter-debug and status memory commands are serviced
// - status memory command in stop does no access, returns stopped error
// - enter-debug during stop with bdm_enable wakes into active debug
// - after debug entry from stop every command is accepted
// - retained stop with debug: cpu ram standby, clock gen regulator active
// - low voltage detector selectable for interrupt or reset
// - lowv detect and stop enables keep regulator active in stop
// - deep stop request with lowv detect and stop both enabled enters retained stop
// - peripheral clocks halt in every stop mode, even with debug
// - converter runs in retained stop only with async clock and detector
// - clock generator oscillator runs in retained stop only if enabled or bdm_enable kept debug
// - wake timer runs in stop only when select was nonzero at entry
// - stop with stop_instr_enable clear forces illegal opcode reset
// - partial_powerdown_select 1 picks deep stop, 0 retained stop
// - deep stop wake sets powerdown_wake_flag until acknowledged
// - pins stay latched after deep stop wake until release written
`timescale 1ns/10ps
`default_nettype none
module smsel_top (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire smsel_pkg::smsel_cfg_t cfg,
	input wire logic stop_instr,
	input wire logic bg_instr,
	input wire logic go_cmd,
	input wire logic reset_pin_n,
	input wire logic irq_pin_n,
	input wire logic async_irq,
	input wire logic wake_timer_evt,
	input wire logic lowv_trip,
	input wire logic lowv_reset_select,
	input wire logic pin_latch_release,
	input wire smsel_pkg::smsel_dbg_req_t dbg_req,
	output smsel_pkg::smsel_dbg_rsp_t dbg_rsp,
	output smsel_pkg::smsel_pwr_t pwr,
	output logic in_stop,
	output logic in_deep_stop,
	output logic active_bg,
	output logic illegal_op_reset,
	output logic deep_wake_reset,
	output logic stop_wake_irq,
	output logic lowv_irq,
	output logic lowv_reset,
	output logic powerdown_wake_flag
);
	import smsel_pkg::*;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_DEEP,
		ST_RETAINED
	} smsel_mode_t;

	typedef struct packed {
		smsel_mode_t mode;
		logic active_bg;
		logic dbg_kept;
		logic reg_kept;
		logic wake_run;
		logic illegal_op;
		logic deep_wake;
		logic stop_irq;
		logic lvi;
		logic lvr;
		logic wake_flag;
		logic pins_latched;
		smsel_pwr_t pwr;
	} smsel_state_t;

	smsel_state_t st_q, st_d;
	logic reset_pin_s_n;
	logic irq_pin_s_n;
	logic lowv_stop_on;
	logic enter_dbg_evt;

	// wake pins come from outside the clock domain
	smsel_sync u_sync_rst (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		.pin_in(reset_pin_n),
		.level_out(reset_pin_s_n)
	);

	smsel_sync u_sync_irq (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		.pin_in(irq_pin_n),
		.level_out(irq_pin_s_n)
	);

	smsel_dbg_filter u_dbg (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		.stopped(st_q.mode != ST_RUN),
		.active_bg(st_q.active_bg),
		.req(dbg_req),
		.rsp(dbg_rsp)
	);

	assign lowv_stop_on = cfg.lowv_detect_enable && cfg.lowv_stop_enable;
	// debug link only survives a stop that kept its clocks
	assign enter_dbg_evt = dbg_req.valid && dbg_req.cmd == SM_CMD_ENTER_DEBUG;

	always_comb begin
		st_d = st_q;
		st_d.illegal_op = 1'b0;
		st_d.deep_wake = 1'b0;
		st_d.stop_irq = 1'b0;
		st_d.lvi = 1'b0;
		st_d.lvr = 1'b0;
		// detector action is chosen by lowv_reset_select
		if (cfg.lowv_detect_enable && lowv_trip) begin
			if (lowv_reset_select) begin
				st_d.lvr = 1'b1;
			end else begin
				st_d.lvi = 1'b1;
			end
		end
		case (st_q.mode)
			ST_RUN: begin
				if (st_q.active_bg) begin
					if (go_cmd) begin
						st_d.active_bg = 1'b0;
					end
				end else if ((bg_instr || enter_dbg_evt) && cfg.bdm_enable) begin
					st_d.active_bg = 1'b1;
				end else if (stop_instr) begin
					if (!cfg.stop_instr_enable) begin
						st_d.illegal_op = 1'b1;
					end else begin
						st_d.dbg_kept = cfg.bdm_enable;
						st_d.reg_kept = cfg.bdm_enable || lowv_stop_on;
						// field sampled once, later writes do not count
						st_d.wake_run = cfg.periodic_wake_select != WAKE_SEL_OFF;
						if (cfg.bdm_enable || lowv_stop_on) begin
							st_d.mode = ST_RETAINED;
						end else if (cfg.partial_powerdown_select) begin
							st_d.mode = ST_DEEP;
							st_d.pins_latched = 1'b1;
						end else begin
							st_d.mode = ST_RETAINED;
						end
					end
				end
			end
			ST_DEEP: begin
				// wake acts as a power-on start, so cpu is reset
				if (!reset_pin_s_n || !irq_pin_s_n || wake_timer_evt) begin
					st_d.mode = ST_RUN;
					st_d.deep_wake = 1'b1;
					st_d.wake_flag = 1'b1;
				end
			end
			ST_RETAINED: begin
				if (st_q.dbg_kept && enter_dbg_evt) begin
					st_d.mode = ST_RUN;
					st_d.active_bg = 1'b1;
				end else if (!reset_pin_s_n) begin
					st_d.mode = ST_RUN;
				end else if (!irq_pin_s_n || async_irq || wake_timer_evt || st_d.lvi) begin
					st_d.mode = ST_RUN;
					st_d.stop_irq = 1'b1;
				end
			end
			default: begin
				st_d.mode = ST_RUN;
			end
		endcase
		if (st_d.mode == ST_RUN) begin
			st_d.dbg_kept = 1'b0;
			st_d.reg_kept = 1'b0;
			st_d.wake_run = 1'b0;
		end
		// release write clears both, only after leaving deep stop
		if (pin_latch_release && st_q.mode == ST_RUN && !st_d.deep_wake) begin
			st_d.wake_flag = 1'b0;
			st_d.pins_latched = 1'b0;
		end
		st_d.pwr = '0;
		case (st_d.mode)
			ST_DEEP: begin
				st_d.pwr.cpu_off = 1'b1;
				st_d.pwr.ram_standby = 1'b1;
				st_d.pwr.pins_held = 1'b1;
				st_d.pwr.wake_timer_run = st_d.wake_run;
			end
			ST_RETAINED: begin
				st_d.pwr.cpu_standby = 1'b1;
				st_d.pwr.ram_standby = 1'b1;
				st_d.pwr.pins_held = 1'b1;
				st_d.pwr.debug_clk_en = st_d.dbg_kept;
				st_d.pwr.regulator_active = st_d.reg_kept;
				st_d.pwr.icg_active = st_d.dbg_kept || cfg.osc_run_in_stop;
				st_d.pwr.adc_active = cfg.adc_async_clk_enable && cfg.lowv_detect_enable;
				st_d.pwr.wake_timer_run = st_d.wake_run;
			end
			default: begin
				st_d.pwr.periph_clk_en = 1'b1;
				st_d.pwr.debug_clk_en = 1'b1;
				st_d.pwr.regulator_active = 1'b1;
				st_d.pwr.icg_active = 1'b1;
				st_d.pwr.adc_active = 1'b1;
				st_d.pwr.wake_timer_run = cfg.periodic_wake_select != WAKE_SEL_OFF;
				st_d.pwr.pins_held = st_d.pins_latched;
			end
		endcase
		// peripheral clocks stay off in stop whatever debug does
		if (st_d.mode != ST_RUN) begin
			st_d.pwr.periph_clk_en = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_q <= '0;
			st_q.mode <= ST_RUN;
			st_q.pwr.periph_clk_en <= 1'b1;
			st_q.pwr.debug_clk_en <= 1'b1;
			st_q.pwr.regulator_active <= 1'b1;
			st_q.pwr.icg_active <= 1'b1;
			st_q.pwr.adc_active <= 1'b1;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign pwr = st_q.pwr;
	assign in_stop = st_q.mode != ST_RUN;
	assign in_deep_stop = st_q.mode == ST_DEEP;
	assign active_bg = st_q.active_bg;
	assign illegal_op_reset = st_q.illegal_op;
	assign deep_wake_reset = st_q.deep_wake;
	assign stop_wake_irq = st_q.stop_irq;
	assign lowv_irq = st_q.lvi;
	assign lowv_reset = st_q.lvr;
	assign powerdown_wake_flag = st_q.wake_flag;
endmodule // smsel_top
`default_nettype wire

// ### smsel_sva.sv
// smsel_sva: port checker for smsel_top
// assumes one clock domain, reset synchronous high
`timescale 1ns/10ps
`default_nettype none
module smsel_sva (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire smsel_pkg::smsel_cfg_t cfg,
	input wire logic stop_instr,
	input wire logic bg_instr,
	input wire logic pin_latch_release,
	input wire smsel_pkg::smsel_dbg_req_t dbg_req,
	input wire smsel_pkg::smsel_dbg_rsp_t dbg_rsp,
	input wire smsel_pkg::smsel_pwr_t pwr,
	input wire logic in_stop,
	input wire logic in_deep_stop,
	input wire logic active_bg,
	input wire logic illegal_op_reset,
	input wire logic powerdown_wake_flag
);
	import smsel_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// enter-debug and bg requests outrank stop when bdm_enable is set, so leave those cycles out
	wire logic go = clk_en && stop_instr && !in_stop && !active_bg && !bg_instr && !dbg_req.valid;
	wire logic ok = go && cfg.stop_instr_enable;
	wire logic keep = cfg.bdm_enable || (cfg.lowv_detect_enable && cfg.lowv_stop_enable);
	wire logic ask = clk_en && dbg_req.valid && in_stop && !active_bg;
	a_stop_illegal: assert property (go && !cfg.stop_instr_enable |=> illegal_op_reset && !in_stop)
		else $error("bad stop not refused");
	a_force_retain: assert property (ok && keep |=> in_stop && !in_deep_stop)
		else $error("retained stop not forced");
	a_deep_select: assert property (ok && !keep && cfg.partial_powerdown_select |=> in_deep_stop)
		else $error("deep stop not taken");
	a_dbg_kept: assert property (ok && cfg.bdm_enable |=> pwr.debug_clk_en && pwr.regulator_active)
		else $error("debug clock or regulator dropped");
	a_periph_halt: assert property (in_stop |-> !pwr.periph_clk_en)
		else $error("peripheral clock in stop");
	a_mem_status: assert property (ask && dbg_req.cmd == SM_CMD_MEM_STATUS
		|=> dbg_rsp.valid && !dbg_rsp.do_access && dbg_rsp.status == DBG_ST_STOPPED)
		else $error("status command wrong in stop");
	a_cmd_reject: assert property (ask && dbg_req.cmd[1] |=> !dbg_rsp.accepted && dbg_rsp.status == DBG_ST_REJECT)
		else $error("command not rejected in stop");
	a_dbg_wake: assert property (ask && dbg_req.cmd == SM_CMD_ENTER_DEBUG && pwr.debug_clk_en
		|=> active_bg && !in_stop)
		else $error("enter debug did not wake");
	a_flag_hold: assert property (powerdown_wake_flag && !(clk_en && pin_latch_release) |=> powerdown_wake_flag)
		else $error("wake flag lost");
	c_deep: cover property (ok ##1 in_deep_stop);
	c_wake: cover property (ask ##1 active_bg);
	c_ill: cover property (illegal_op_reset);
endmodule // smsel_sva
bind smsel_top smsel_sva u_sva (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .cfg(cfg),
	.stop_instr(stop_instr), .bg_instr(bg_instr), .pin_latch_release(pin_latch_release), .dbg_req(dbg_req),
	.dbg_rsp(dbg_rsp), .pwr(pwr), .in_stop(in_stop), .in_deep_stop(in_deep_stop), .active_bg(active_bg),
	.illegal_op_reset(illegal_op_reset), .powerdown_wake_flag(powerdown_wake_flag));
`default_nettype wire

// ### smsel_host.sv
// smsel_host: cpu stop pulses and serial debug host
// assumes tasks are entered at a falling edge
`timescale 1ns/10ps
`default_nettype none
module smsel_host (
	input wire logic core_clk,
	input wire smsel_pkg::smsel_dbg_rsp_t dbg_rsp,
	output logic stop_instr,
	output smsel_pkg::smsel_dbg_req_t dbg_req
);
	import smsel_pkg::*;
	initial begin
		stop_instr = 1'b0;
		dbg_req = '0;
	end
	task automatic stop_pulse();
		@(negedge core_clk) stop_instr = 1'b1;
		@(negedge core_clk) stop_instr = 1'b0;
	endtask
	// answer is a one-cycle pulse, caught as the request drops
	task automatic send(input smsel_cmd_t c, output smsel_dbg_rsp_t r);
		@(negedge core_clk) dbg_req = '{1'b1, c};
		@(negedge core_clk) dbg_req = '0;
		r = dbg_rsp;
	endtask
endmodule // smsel_host
`default_nettype wire

// ### test_stop_mode_selector.sv
// test_stop_mode_selector: bench with reference model
// assumes host model drives stop and debug pulses
`timescale 1ns/10ps
`default_nettype none
module test_stop_mode_selector;
	import smsel_pkg::*;
	logic core_clk, reset, stop_instr, in_stop, in_deep_stop, active_bg, illegal_op_reset, deep_wake_reset;
	logic go_cmd = 1'b0, bg_instr = 1'b0, irq_pin_n = 1'b1, async_irq = 1'b0, lowv_trip = 1'b0;
	logic lowv_reset_select = 1'b0, pin_latch_release = 1'b0;
	logic stop_wake_irq, lowv_irq, lowv_reset, powerdown_wake_flag, deep, keep;
	smsel_cfg_t cfg = '0;
	smsel_dbg_req_t dbg_req;
	smsel_dbg_rsp_t dbg_rsp, r;
	smsel_pwr_t pwr;
	int n_mismatch = 0;
	int compares = 0;
	smsel_host u_host (.core_clk(core_clk), .dbg_rsp(dbg_rsp), .stop_instr(stop_instr), .dbg_req(dbg_req));
	smsel_top u_dut (.core_clk(core_clk), .reset(reset), .clk_en(1'b1), .cfg(cfg), .stop_instr(stop_instr),
		.bg_instr(bg_instr), .go_cmd(go_cmd), .reset_pin_n(1'b1), .irq_pin_n(irq_pin_n), .async_irq(async_irq),
		.wake_timer_evt(1'b0), .lowv_trip(lowv_trip), .lowv_reset_select(lowv_reset_select),
		.pin_latch_release(pin_latch_release), .dbg_req(dbg_req), .dbg_rsp(dbg_rsp), .pwr(pwr),
		.in_stop(in_stop), .in_deep_stop(in_deep_stop), .active_bg(active_bg),
		.illegal_op_reset(illegal_op_reset), .deep_wake_reset(deep_wake_reset), .stop_wake_irq(stop_wake_irq),
		.lowv_irq(lowv_irq), .lowv_reset(lowv_reset), .powerdown_wake_flag(powerdown_wake_flag));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(negedge core_clk) s = 1'b1;
		@(negedge core_clk) s = 1'b0;
	endtask
	// pin wake goes through the synchroniser, so allow a few cycles
	task automatic wake_wait();
		for (int i = 0; i < 12 && in_stop; i++)
			@(negedge core_clk);
		if (in_stop) begin
			n_mismatch++;
			print_verdict();
		end
	endtask
	task automatic cmd(input smsel_cmd_t c, input logic [4:0] e);
		u_host.send(c, r);
		chk("rsp", {r.valid, r.accepted, r.status}, {1'b1, e});
	endtask
	task automatic stop_test(input smsel_cfg_t c);
		cfg = c;
		keep = c.bdm_enable | (c.lowv_detect_enable & c.lowv_stop_enable);
		deep = c.partial_powerdown_select & ~keep;
		u_host.stop_pulse();
		chk("stop", {illegal_op_reset, in_stop}, {~c.stop_instr_enable, c.stop_instr_enable});
		if (c.stop_instr_enable) begin
			chk("deep", in_deep_stop, deep);
			chk("pwr", pwr[9:1], {~deep, deep, 1'b1, 1'b0, c.bdm_enable, keep, ~deep & (c.bdm_enable | c.osc_run_in_stop),
				~deep & c.adc_async_clk_enable & c.lowv_detect_enable, |c.periodic_wake_select});
			if (deep) begin
				@(negedge core_clk) irq_pin_n = 1'b0;
				wake_wait();
				chk("wake_rst", deep_wake_reset, 1'b1);
				irq_pin_n = 1'b1;
				repeat (3) @(negedge core_clk);
				chk("held", {powerdown_wake_flag, pwr.pins_held}, 2'b11);
				pulse(pin_latch_release);
				chk("released", {powerdown_wake_flag, pwr.pins_held}, 2'b00);
			end else begin
				pulse(async_irq);
				chk("irq_wake", {in_stop, stop_wake_irq}, 2'b01);
			end
		end
		repeat (6) @(negedge core_clk);
	endtask
	initial begin
		reset = 1'b1;
		void'($urandom(87));
		repeat (2) @(negedge core_clk);
		reset = 1'b0;
		repeat (4) @(negedge core_clk);
		for (int i = 0; i < 2; i++) begin
			cfg.bdm_enable = i[0];
			pulse(bg_instr);
			chk("bg_entry", active_bg, i[0]);
			pulse(go_cmd);
		end
		cfg.lowv_detect_enable = 1'b1;
		for (int i = 0; i < 2; i++) begin
			lowv_reset_select = i[0];
			pulse(lowv_trip);
			chk("lowv", {lowv_reset, lowv_irq}, {i[0], ~i[0]});
		end
		$display("test run_events done");
		cfg = '0;
		cfg.bdm_enable = 1'b1;
		cfg.stop_instr_enable = 1'b1;
		cfg.partial_powerdown_select = 1'b1;
		u_host.stop_pulse();
		chk("retained", {in_stop, in_deep_stop}, 2'b10);
		cmd(SM_CMD_MEM_STATUS, {1'b1, DBG_ST_STOPPED});
		chk("no_access", r.do_access, 1'b0);
		cmd(SM_CMD_NONINTRUSIVE, {1'b0, DBG_ST_REJECT});
		cmd(SM_CMD_ACTIVE_ONLY, {1'b0, DBG_ST_REJECT});
		cmd(SM_CMD_ENTER_DEBUG, {1'b1, DBG_ST_OK});
		chk("woke_bg", {in_stop, active_bg}, 2'b01);
		cmd(SM_CMD_ACTIVE_ONLY, {1'b1, DBG_ST_OK});
		cmd(SM_CMD_MEM_STATUS, {1'b1, DBG_ST_OK});
		pulse(go_cmd);
		$display("test debug_stop done");
		stop_test(10'h030);
		stop_test(10'h070);
		stop_test(10'h1f1);
		stop_test(10'h0b1);
		for (int i = 0; i < 24; i++)
			stop_test(10'($urandom));
		$display("test stop_modes done");
		print_verdict();
	end
endmodule // test_stop_mode_selector
`default_nettype wire
